// ### logic/bru_branch_unit.v
// branch execution unit with wishbone register access and memory port
`include "bru_defines.vh"
module bru_branch_unit #(
    parameter LEVELS = 8,
    parameter [7:0] TRAP_MASK = 8'h03
) (
    // clock and reset
    input wire CLOCK_IN,
    input wire SYS_RST_IN,
    // wishbone slave
    input wire WB_CYC_IN,
    input wire WB_STB_IN,
    input wire WB_WE_IN,
    input wire [7:0] WB_ADR_IN,
    input wire [3:0] WB_SEL_IN,
    input wire [31:0] WB_DAT_IN,
    output wire [31:0] WB_DAT_OUT,
    output wire WB_ACK_OUT,
    // memory port
    output wire MEM_REQ_OUT,
    output wire MEM_WE_OUT,
    output wire [15:0] MEM_ADDR_OUT,
    output wire [23:0] MEM_WDATA_OUT,
    input wire [23:0] MEM_RDATA_IN,
    input wire MEM_ACK_IN,
    // status
    output wire BUSY_OUT,
    output wire EXT_INT_BLOCK_OUT,
    output wire USER_MODE_OUT,
    output wire [7:0] ACTIVE_INT_OUT
);
    localparam ST_IDLE = 3'd0;
    localparam ST_DECODE = 3'd1;
    localparam ST_FETCH = 3'd2;
    localparam ST_EXEC = 3'd3;
    localparam ST_STORE = 3'd4;

    reg [2:0] state_r;
    reg [23:0] ir_r;
    reg [15:0] p_r;
    reg [23:0] i_r;
    reg [23:0] j_r;
    reg [23:0] k_r;
    reg [3:0] cond_r;
    reg user_r;
    reg hold_r;
    reg block_r;
    reg [7:0] act_r;
    reg [15:0] ea_r;
    reg [23:0] last_r;
    reg chained_r;
    reg mreq_r;
    reg mwe_r;
    reg [23:0] mwdat_r;
    reg ack_r;
    reg [31:0] dat_r;

    // index register read by selector; selector 0 reads as zero
    function [23:0] idx_val;
        input [1:0] sel;
        input [23:0] v1;
        input [23:0] v2;
        input [23:0] v3;
        begin
            case (sel) // [RQ7]
                2'd1: idx_val = v1;
                2'd2: idx_val = v2;
                2'd3: idx_val = v3;
                default: idx_val = 24'h000000;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        begin
            merge = (old & ~{{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}})
                | (nw & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}});
        end
    endfunction

    // lowest set bit, used as the highest-priority level
    function [7:0] lowest;
        input [7:0] v;
        begin
            lowest = v & (~v + 8'h01);
        end
    endfunction

    wire [5:0] op = ir_r[`BRU_OP_HI:`BRU_OP_LO];
    wire ind = ir_r[`BRU_IND_BIT];
    wire [2:0] sel = ir_r[`BRU_SEL_HI:`BRU_SEL_LO];
    wire var_b = ir_r[`BRU_VAR_BIT];
    wire is_long = (op == `BRU_OP_JSAVE) || (op == `BRU_OP_JLONG)
        || ((op == `BRU_OP_JINC) && var_b);
    wire ind_ok = (op == `BRU_OP_JSHORT) || (op == `BRU_OP_JCOND)
        || (op == `BRU_OP_JLINK) || (op == `BRU_OP_JSAVE) || (op == `BRU_OP_JLONG);
    wire [15:0] addr0 = is_long ? ir_r[15:0] : {2'b00, ir_r[`BRU_SADR_HI:0]};
    // only the short jump and the indexed long form index the immediate
    wire [23:0] add0 = (op == `BRU_OP_JSHORT) ? idx_val(sel[1:0], i_r, j_r, k_r) :
        ((op == `BRU_OP_JINC) && var_b) ? j_r : 24'h000000; // [RQ3] [RQ8]
    wire [15:0] ea0 = addr0 + add0[15:0];
    wire [23:0] cw_idx = idx_val(MEM_RDATA_IN[`BRU_CW_XHI:`BRU_CW_XLO], i_r, j_r, k_r);
    wire [15:0] p_inc = p_r + 16'h0001;
    wire [15:0] p_short = {p_r[15], ea_r[14:0]};
    wire [23:0] sel_reg = idx_val(sel[1:0], i_r, j_r, k_r);
    wire [23:0] inc_reg = sel_reg + 24'h000001;
    wire step_first = (sel == `BRU_BSTEP_FIRST);
    wire [23:0] step_reg = step_first ? i_r : j_r;
    wire [1:0] step_hi = step_reg[23:22] + 2'b01;
    wire [21:0] step_lo = step_reg[21:0] + 22'h000001;
    wire [7:0] elig = hold_r ? (act_r & TRAP_MASK) : act_r;
    wire cond_taken;
    wire wb_req = WB_CYC_IN && WB_STB_IN;
    wire wb_wr = wb_req && ack_r && WB_WE_IN;
    wire idle = (state_r == ST_IDLE);
    // merged bus words; only the low bits of each register are kept
    wire [31:0] mrg_p = merge({16'h0000, p_r}, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] mrg_i = merge({8'h00, i_r}, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] mrg_j = merge({8'h00, j_r}, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] mrg_k = merge({8'h00, k_r}, WB_DAT_IN, WB_SEL_IN);

    bru_cond_test u_cond (
        .cond_in(cond_r),
        .sel_in(sel),
        .taken_out(cond_taken)
    );

    // bus reply: one-cycle ack, data captured in the same cycle
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= wb_req && !ack_r;
            if (wb_req && !ack_r) begin
                case (WB_ADR_IN)
                    `BRU_REG_INSTR: dat_r <= {8'h00, ir_r};
                    `BRU_REG_STATUS: dat_r <= {28'h0000000, hold_r, user_r, block_r, !idle};
                    `BRU_REG_PADDR: dat_r <= {16'h0000, p_r};
                    `BRU_REG_IDX1: dat_r <= {8'h00, i_r};
                    `BRU_REG_IDX2: dat_r <= {8'h00, j_r};
                    `BRU_REG_IDX3: dat_r <= {8'h00, k_r};
                    `BRU_REG_COND: dat_r <= {28'h0000000, cond_r};
                    `BRU_REG_ACTIVE: dat_r <= {24'h000000, act_r};
                    default: dat_r <= 32'h00000000;
                endcase
            end
        end
    end

    // software writes land only while idle, so the engine owns every register when busy
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            state_r <= ST_IDLE;
            ir_r <= 24'h000000;
            p_r <= `BRU_RST_PADDR;
            i_r <= 24'h000000;
            j_r <= 24'h000000;
            k_r <= 24'h000000;
            cond_r <= `BRU_RST_COND;
            user_r <= 1'b0;
            hold_r <= 1'b0;
            block_r <= 1'b0;
            act_r <= 8'h00;
            ea_r <= 16'h0000;
            last_r <= 24'h000000;
            chained_r <= 1'b0;
            mreq_r <= 1'b0;
            mwe_r <= 1'b0;
            mwdat_r <= 24'h000000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (wb_wr) begin
                        case (WB_ADR_IN)
                            `BRU_REG_INSTR: begin
                                if (WB_SEL_IN == 4'hf || WB_SEL_IN[2:0] == 3'h7) begin
                                    ir_r <= WB_DAT_IN[23:0];
                                    state_r <= ST_DECODE;
                                end
                            end
                            `BRU_REG_STATUS: begin
                                if (WB_SEL_IN[0]) begin
                                    user_r <= WB_DAT_IN[`BRU_ST_USER];
                                    hold_r <= WB_DAT_IN[`BRU_ST_HOLD];
                                end
                            end
                            `BRU_REG_PADDR: p_r <= mrg_p[15:0];
                            `BRU_REG_IDX1: i_r <= mrg_i[23:0];
                            `BRU_REG_IDX2: j_r <= mrg_j[23:0];
                            `BRU_REG_IDX3: k_r <= mrg_k[23:0];
                            `BRU_REG_COND: if (WB_SEL_IN[0]) cond_r <= WB_DAT_IN[3:0];
                            `BRU_REG_ACTIVE: if (WB_SEL_IN[0]) act_r <= WB_DAT_IN[7:0];
                            default: ;
                        endcase
                    end
                end
                ST_DECODE: begin
                    ea_r <= ea0; // [RQ23]
                    chained_r <= 1'b0;
                    // link lands before any indirection, so the chain sees it
                    if (op == `BRU_OP_JLINK) begin
                        case (sel[1:0]) // [RQ9] [RQ10]
                            2'd1: i_r <= {8'h00, p_inc};
                            2'd2: j_r <= {8'h00, p_inc};
                            2'd3: k_r <= {8'h00, p_inc};
                            default: ;
                        endcase
                    end
                    if (op == `BRU_OP_JLONG && var_b)
                        j_r <= {8'h00, p_inc}; // [RQ11] [RQ10]
                    state_r <= (ind_ok && ind) ? ST_FETCH : ST_EXEC; // [RQ23]
                end
                ST_FETCH: begin
                    if (!mreq_r) begin
                        mreq_r <= 1'b1;
                        mwe_r <= 1'b0;
                    end else if (MEM_ACK_IN) begin
                        mreq_r <= 1'b0;
                        last_r <= MEM_RDATA_IN;
                        chained_r <= 1'b1;
                        // chain words may be indexed even where the immediate may not
                        ea_r <= MEM_RDATA_IN[15:0] + cw_idx[15:0]; // [RQ3] [RQ23]
                        if (!MEM_RDATA_IN[`BRU_CW_IND])
                            state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_r <= ST_IDLE;
                    block_r <= 1'b0;
                    case (op)
                        `BRU_OP_JSHORT: p_r <= p_short; // [RQ1]
                        `BRU_OP_JCOND: p_r <= cond_taken ? ea_r : p_inc; // [RQ4] [RQ24]
                        `BRU_OP_JINC: begin
                            if (var_b) begin
                                p_r <= ea_r; // [RQ8]
                            end else begin
                                case (sel[1:0]) // [RQ6]
                                    2'd1: i_r <= inc_reg;
                                    2'd2: j_r <= inc_reg;
                                    2'd3: k_r <= inc_reg;
                                    default: ;
                                endcase
                                p_r <= (inc_reg != 24'h000000) ? ea_r : p_inc; // [RQ6] [RQ24]
                            end
                        end
                        `BRU_OP_JLINK: p_r <= p_short; // [RQ9]
                        `BRU_OP_JSAVE: begin
                            if (!var_b) begin
                                mreq_r <= 1'b1;
                                mwe_r <= 1'b1;
                                mwdat_r <= {3'b000, user_r, cond_r, p_inc}; // [RQ13] [RQ14]
                                state_r <= ST_STORE;
                            end else begin
                                // held externals survive; the highest active executive trap is reset even while held
                                act_r <= act_r & ~lowest(elig); // [RQ16] [RQ18] [RQ19]
                                if (chained_r) begin
                                    cond_r <= last_r[`BRU_LW_CHI:`BRU_LW_CLO]; // [RQ17] [RQ22]
                                    if (!user_r)
                                        user_r <= last_r[`BRU_LW_MODE]; // [RQ21]
                                end
                                p_r <= ea_r; // [RQ16] [RQ17]
                                block_r <= 1'b1; // [RQ22]
                            end
                        end
                        `BRU_OP_JLONG: p_r <= ea_r; // [RQ2] [RQ11]
                        `BRU_OP_BSTEP: begin
                            if (step_hi != 2'b00) begin
                                if (step_first)
                                    i_r <= {step_hi, step_reg[21:0]}; // [RQ20]
                                else
                                    j_r <= {step_hi, step_reg[21:0]}; // [RQ20]
                                p_r <= p_short;
                            end else if (step_lo != 22'h000000) begin
                                if (step_first)
                                    i_r <= {2'b01, step_lo}; // [RQ20]
                                else
                                    j_r <= {2'b01, step_lo}; // [RQ20]
                                p_r <= p_short;
                            end else begin
                                if (step_first)
                                    i_r <= `BRU_BSTEP_WRAP; // [RQ20]
                                else
                                    j_r <= `BRU_BSTEP_WRAP; // [RQ20]
                                p_r <= p_inc; // [RQ24]
                            end
                        end
                        default: p_r <= p_inc;
                    endcase
                end
                ST_STORE: begin
                    if (MEM_ACK_IN) begin
                        mreq_r <= 1'b0;
                        mwe_r <= 1'b0;
                        p_r <= ea_r + 16'h0001; // [RQ12]
                        block_r <= 1'b1; // [RQ15]
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign WB_DAT_OUT = dat_r;
    assign WB_ACK_OUT = ack_r;
    assign MEM_REQ_OUT = mreq_r;
    assign MEM_WE_OUT = mwe_r;
    assign MEM_ADDR_OUT = ea_r;
    assign MEM_WDATA_OUT = mwdat_r;
    assign BUSY_OUT = !idle;
    assign EXT_INT_BLOCK_OUT = block_r;
    assign USER_MODE_OUT = user_r;
    assign ACTIVE_INT_OUT = act_r;
endmodule // bru_branch_unit

// ### logic/bru_cond_test.v
// condition selector decode for the conditional jump
`include "bru_defines.vh"
module bru_cond_test (
    // inputs
    input wire [3:0] cond_in,
    input wire [2:0] sel_in,
    // result
    output wire taken_out
);
    reg hit;
    always @* begin
        case (sel_in[1:0]) // [RQ5]
            2'd0: hit = cond_in[`BRU_C_OV];
            2'd1: hit = cond_in[`BRU_C_NEG];
            2'd2: hit = cond_in[`BRU_C_ZERO];
            default: hit = cond_in[`BRU_C_POS];
        endcase
    end
    // upper half of the selector asks for the negated condition
    assign taken_out = hit ^ sel_in[2]; // [RQ5]
endmodule // bru_cond_test

// ### logic/bru_defines.vh
// constants and field layout for the branch instruction unit
// Notes on behaviour
// [RQ1] short jump loads 15-bit address
// [RQ2] long jump loads full 16-bit address
// [RQ3] long/link forms never index immediate reference
// [RQ4] condition jump: taken loads address, else next
// [RQ5] selector: ov, neg, zero, pos, then negations
// [RQ6] increment index; nonzero result jumps
// [RQ7] index selector 1, 2, 3 picks register
// [RQ8] indexed long always adds second index
// [RQ9] link writes next address, short jump
// [RQ10] link value written before indexing or indirection
// [RQ11] long link writes second index register
// [RQ12] save-return stores link word, continues after
// [RQ13] link word: condition 19-16, return 15-0
// [RQ14] link bit 20 records user mode
// [RQ15] save-return blocks external interrupts one instruction
// [RQ16] reset-interrupt clears highest active level, jumps
// [RQ17] indirect reset-interrupt restores condition, returns
// [RQ18] held external interrupts stay active
// [RQ19] executive traps reset even while held
// [RQ20] byte-step increments byte field then word
// [RQ21] indirect reset-interrupt in monitor sets mode
// [RQ22] direct reset-interrupt keeps condition, blocks interrupts
// [RQ23] effective address follows indirect chain with indexing
// [RQ24] untaken branch only advances program address
`ifndef BRU_DEFINES_VH
`define BRU_DEFINES_VH
// instruction fields
`define BRU_OP_HI 23
`define BRU_OP_LO 18
`define BRU_IND_BIT 17
`define BRU_VAR_BIT 16
`define BRU_SEL_HI 16
`define BRU_SEL_LO 14
`define BRU_SADR_HI 13
// opcodes
`define BRU_OP_JSHORT 6'o21
`define BRU_OP_JCOND 6'o22
`define BRU_OP_JINC 6'o23
`define BRU_OP_JLINK 6'o24
`define BRU_OP_JSAVE 6'o25
`define BRU_OP_JLONG 6'o26
`define BRU_OP_BSTEP 6'o60
`define BRU_BSTEP_FIRST 3'd7
`define BRU_BSTEP_SECOND 3'd6
// chain word fields
`define BRU_CW_IND 23
`define BRU_CW_XHI 22
`define BRU_CW_XLO 21
`define BRU_LW_MODE 20
`define BRU_LW_CHI 19
`define BRU_LW_CLO 16
`define BRU_BSTEP_WRAP 24'h400000
// condition register bits
`define BRU_C_OV 3
`define BRU_C_NEG 2
`define BRU_C_ZERO 1
`define BRU_C_POS 0
// register byte offsets
`define BRU_REG_INSTR 8'h00
`define BRU_REG_STATUS 8'h04
`define BRU_REG_PADDR 8'h08
`define BRU_REG_IDX1 8'h0c
`define BRU_REG_IDX2 8'h10
`define BRU_REG_IDX3 8'h14
`define BRU_REG_COND 8'h18
`define BRU_REG_ACTIVE 8'h1c
// status bits
`define BRU_ST_BUSY 0
`define BRU_ST_BLOCK 1
`define BRU_ST_USER 2
`define BRU_ST_HOLD 3
// reset values
`define BRU_RST_PADDR 16'h0000
`define BRU_RST_COND 4'h0
`endif

// ### tb/bru_branch_unit_chk.sv
// port-level assertions for the branch execution unit
module bru_branch_unit_chk (
    // clock and reset
    input wire CLOCK_IN,
    input wire SYS_RST_IN,
    // wishbone
    input wire WB_CYC_IN,
    input wire WB_STB_IN,
    input wire WB_ACK_OUT,
    // memory port
    input wire MEM_REQ_OUT,
    input wire MEM_WE_OUT,
    input wire [15:0] MEM_ADDR_OUT,
    input wire [23:0] MEM_WDATA_OUT,
    input wire MEM_ACK_IN,
    // status
    input wire BUSY_OUT,
    input wire EXT_INT_BLOCK_OUT,
    input wire USER_MODE_OUT,
    input wire [7:0] ACTIVE_INT_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    a_ack_next_cycle: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
        else $error("bus request not answered next cycle");
    a_ack_one_cycle: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("bus ack longer than one cycle");
    a_mem_req_stands: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT
        && $stable(MEM_ADDR_OUT) && $stable(MEM_WE_OUT) && $stable(MEM_WDATA_OUT))
        else $error("memory request changed before ack");
    a_mem_req_drop: assert property (MEM_REQ_OUT && MEM_ACK_IN |=> !MEM_REQ_OUT)
        else $error("memory request held after ack");
    a_req_only_busy: assert property (MEM_REQ_OUT |-> BUSY_OUT)
        else $error("memory request outside an instruction");
    a_busy_bounded: assert property ($rose(BUSY_OUT) |-> ##[1:60] !BUSY_OUT)
        else $error("instruction never completed");
    a_save_blocks_int: assert property (MEM_REQ_OUT && MEM_WE_OUT && MEM_ACK_IN
        |-> ##[1:2] EXT_INT_BLOCK_OUT)
        else $error("interrupt block missing after save");
    a_link_word_form: assert property (MEM_REQ_OUT && MEM_WE_OUT |-> MEM_WDATA_OUT[23:21]
        == 3'b000 && MEM_WDATA_OUT[20] == USER_MODE_OUT)
        else $error("link word upper bits wrong");
    // software may rewrite the levels while idle; only the engine is limited to one
    a_one_level_reset: assert property ($past(BUSY_OUT) |-> $onehot0($past(ACTIVE_INT_OUT) & ~ACTIVE_INT_OUT))
        else $error("more than one level reset at once");
endmodule // bru_branch_unit_chk
bind bru_branch_unit bru_branch_unit_chk bru_branch_unit_chk_inst (
    .CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN), .WB_CYC_IN(WB_CYC_IN),
    .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT), .MEM_REQ_OUT(MEM_REQ_OUT),
    .MEM_WE_OUT(MEM_WE_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT),
    .MEM_ACK_IN(MEM_ACK_IN), .BUSY_OUT(BUSY_OUT), .EXT_INT_BLOCK_OUT(EXT_INT_BLOCK_OUT),
    .USER_MODE_OUT(USER_MODE_OUT), .ACTIVE_INT_OUT(ACTIVE_INT_OUT)
);

// ### tb/bru_mem_model.sv
// behavioural main memory answering the unit's word requests
module bru_mem_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // request side
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [15:0] addr_in,
    input wire logic [23:0] wdata_in,
    input wire logic slow_in,
    // answer side
    output logic [23:0] rdata_out,
    output logic ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem [0:65535];
    logic cool = 1'b0;
    int wait_n = 0;
    initial rdata_out = 24'h5a5a5a;
    initial ack_out = 1'b0;
    // data toggles outside ack so a late sample never sees a plausible word
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        cool <= 1'b0;
        if (rst_in) begin
            wait_n <= 0;
        end else if (!cool && req_in) begin
            if (wait_n < (slow_in ? 3 : 0)) begin
                wait_n <= wait_n + 1;
            end else begin
                ack_out <= 1'b1;
                cool <= 1'b1;
                wait_n <= 0;
                if (we_in) mem[addr_in] <= wdata_in;
                else rdata_out <= mem[addr_in];
            end
        end
    end
endmodule // bru_mem_model

// ### tb/tb.sv
// self-checking bench for the branch execution unit against a register model
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cyc, stb, we, slow, ack, mreq, mwe, mack, busy, blk_o, user_o;
    logic [7:0] adr, act_o, act;
    logic [31:0] dat_w, dat_r, rv;
    logic [15:0] maddr, p;
    logic [23:0] mwd, mrd, wd;
    logic [23:0] x [0:3];
    logic [3:0] c;
    logic um, hold, blk;
    logic [8:0] tab [4] = '{9'h148, 9'h019, 9'h01d, 9'h1fe};
    int err_count, checked;
    bru_branch_unit bru_branch_unit_inst (
        .CLOCK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r),
        .WB_ACK_OUT(ack), .MEM_REQ_OUT(mreq), .MEM_WE_OUT(mwe), .MEM_ADDR_OUT(maddr),
        .MEM_WDATA_OUT(mwd), .MEM_RDATA_IN(mrd), .MEM_ACK_IN(mack), .BUSY_OUT(busy),
        .EXT_INT_BLOCK_OUT(blk_o), .USER_MODE_OUT(user_o), .ACTIVE_INT_OUT(act_o)
    );
    bru_mem_model bru_mem_model_inst (
        .clk_in(clk), .rst_in(rst), .req_in(mreq), .we_in(mwe), .addr_in(maddr),
        .wdata_in(mwd), .slow_in(slow), .rdata_out(mrd), .ack_out(mack)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d of %0d comparisons", err_count, checked);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ack is read right at the edge, before that edge's updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, dat_w} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rv = dat_r;
        {cyc, stb, we} <= 3'b000;
        if (n >= 50) err_count++;
        @(posedge clk);
    endtask
    task automatic setup(input logic [15:0] pv, input logic [3:0] cv, input logic [7:0] av,
                         input logic u, input logic h);
        {p, c, act, um, hold} = {pv, cv, av, u, h};
        slow <= 1'($urandom);
        wb(1, 8'h08, {16'h0, p});
        wb(1, 8'h18, {28'h0, c});
        wb(1, 8'h1c, {24'h0, act});
        wb(1, 8'h04, {28'h0, hold, um, 2'b00});
        for (int r = 1; r < 4; r++) begin
            x[r] = 24'($urandom) & 24'h000fff;
            wb(1, 8'h08 + 8'(4 * r), {8'h0, x[r]});
        end
    endtask
    task automatic regs_check;
        wb(0, 8'h08, 0);
        check(rv, {16'h0, p});
        for (int r = 1; r < 4; r++) begin
            wb(0, 8'h08 + 8'(4 * r), 0);
            check(rv, {8'h0, x[r]});
        end
        wb(0, 8'h18, 0);
        check(rv, {28'h0, c});
        wb(0, 8'h1c, 0);
        check(rv, {24'h0, act});
        wb(0, 8'h04, 0);
        check(rv, {28'h0, hold, um, blk, 1'b0});
        check({22'h0, blk_o, user_o, act_o}, {22'h0, blk, um, act});
    endtask
    task automatic step(input logic [23:0] ins);
        logic [2:0] s;
        logic [15:0] nx;
        logic [7:0] e;
        s = ins[16:14];
        nx = p + 16'h1;
        blk = 1'b0;
        case (ins[23:18])
            6'o21: p = {p[15], 15'({1'b0, ins[13:0]} + x[s][14:0])};
            6'o22: p = (c[3 - int'(s[1:0])] ^ s[2]) ? {2'b0, ins[13:0]} : nx;
            6'o23: begin
                if (s[2]) begin
                    p = ins[15:0] + x[2][15:0];
                end else begin
                    x[s] = x[s] + 24'h1;
                    p = (x[s] != 0) ? {2'b0, ins[13:0]} : nx;
                end
            end
            6'o24: begin
                x[s] = {8'h0, nx};
                p = {p[15], 1'b0, ins[13:0]};
            end
            6'o25: begin
                blk = 1'b1;
                if (ins[16]) begin
                    e = hold ? act & 8'h03 : act;
                    act = act & ~(e & (~e + 8'h1));
                    p = ins[15:0];
                end else begin
                    wd = {3'b0, um, c, nx};
                    p = ins[15:0] + 16'h1;
                end
            end
            default: begin
                if (ins[16]) x[2] = {8'h0, nx};
                p = ins[15:0];
            end
        endcase
    endtask
    task automatic exec(input logic [23:0] ins, input bit model);
        int n;
        if (model) step(ins);
        wb(1, 8'h00, {8'h0, ins});
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 200);
        if (n >= 200) err_count++;
        regs_check();
    endtask
    initial begin
        logic [15:0] a;
        {rst, cyc, stb, we, slow, adr, dat_w} = {1'b1, 4'h0, 8'h0, 32'h0};
        {p, c, act, um, hold, blk} = '0;
        x = '{24'h0, 24'h0, 24'h0, 24'h0};
        err_count = 0;
        checked = 0;
        rv = $urandom(46);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        regs_check();
        wb(1, 8'h40, 32'hffffffff);
        wb(0, 8'h40, 0);
        check(rv, 32'h0);
        for (int n = 0; n < 128; n++) begin
            setup(16'(n * 5), 4'(n), 8'h0, 1'b0, 1'b0);
            exec({6'o22, 1'b0, 3'(n >> 4), 14'($urandom)}, 1);
        end
        for (int s = 0; s < 4; s++) begin
            setup(16'($urandom) & 16'h3fff, 4'h0, 8'h0, 1'b0, 1'b0);
            exec({6'o21, 1'b0, 3'(s), 14'($urandom)}, 1);
            if (s > 0) begin
                exec({6'o24, 1'b0, 3'(s), 14'($urandom)}, 1);
                x[s] = 24'hffffff;
                wb(1, 8'h08 + 8'(4 * s), {8'h0, x[s]});
                exec({6'o23, 1'b0, 3'(s), 14'($urandom)}, 1);
                exec({6'o23, 1'b0, 3'(s), 14'($urandom)}, 1);
            end
        end
        exec({6'o23, 2'b01, 16'($urandom)}, 1);
        exec({6'o26, 2'b00, 16'($urandom)}, 1);
        exec({6'o26, 2'b01, 16'($urandom)}, 1);
        for (int u = 0; u < 2; u++) begin
            setup(16'h0100, 4'($urandom), 8'h0, 1'(u), 1'b0);
            a = 16'($urandom);
            exec({6'o25, 2'b00, a}, 1);
            check({8'h0, bru_mem_model_inst.mem[a]}, {8'h0, wd});
        end
        foreach (tab[i]) begin
            setup(16'h0200, 4'h9, tab[i][8:1], 1'b0, tab[i][0]);
            exec({6'o25, 2'b01, 16'($urandom)}, 1);
        end
        for (int u = 0; u < 2; u++) begin
            setup(16'h0300, 4'h2, 8'h30, 1'(u), 1'b0);
            bru_mem_model_inst.mem[16'h0400] = {3'b0, 1'(1 - u), 4'h5, 16'(16'h1234 + u)};
            {c, p, um, act, blk} = {4'h5, 16'(16'h1234 + u), 1'b1, 8'h20, 1'b1};
            exec({6'o25, 2'b11, 16'h0400}, 0);
        end
        setup(16'h0500, 4'h0, 8'h0, 1'b0, 1'b0);
        bru_mem_model_inst.mem[16'h0600] = {1'b1, 2'd1, 5'h0, 16'h0700};
        bru_mem_model_inst.mem[16'h0700 + x[1][15:0]] = {8'h0, 16'h2468};
        {p, blk} = {16'h2468, 1'b0};
        exec({6'o26, 2'b10, 16'h0600}, 0);
        setup(16'h0800, 4'h0, 8'h0, 1'b0, 1'b0);
        bru_mem_model_inst.mem[16'h0900] = {1'b0, 2'd1, 5'h0, 16'h1000};
        {x[1], p} = {24'h000801, 16'h1801};
        exec({6'o24, 1'b1, 3'd1, 14'h0900}, 0);
        test_done();
    end
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule // tb
